/* hdl/cmc_regs.svh */
// Constants for the core memory cycle timing block.
// Assumes inclusion by bare name from each design file.
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH
`define CMC_T01 4'h1
`define CMC_T02 4'h2
`define CMC_T03 4'h3
`define CMC_T04 4'h4
`define CMC_T05 4'h5
`define CMC_T10 4'ha
`define CMC_T12 4'hc
`define CMC_PH3 3'h3
`define CMC_PH4 3'h4
`define CMC_PH5 3'h5
`define CMC_SBIT11 10
`define CMC_SBIT12 11
`define CMC_X_LSB 0
`define CMC_X_MSB 5
`define CMC_Y_LSB 6
`define CMC_Y_MSB 10
`define CMC_OFF_CTRL 8'h00
`define CMC_OFF_STATUS 8'h04
`define CMC_OFF_CYCLES 8'h08
`define CMC_OFF_WORD 8'h0c
`define CMC_WORD_MASK 8'hfc
`define CMC_CTRL_EN 0
`define CMC_CTRL_CLAMP 1
`define CMC_CTRL_RST 2'h1
`endif

/* hdl/cmc_pkg.sv */
// Types shared by the core memory cycle timing block.
// Assumes nothing of its surroundings.
package cmc_pkg;
  typedef enum logic [1:0] {
    CMC_OKAY   = 2'h0,
    CMC_SLVERR = 2'h2
  } cmc_resp_e;
  typedef logic [3:0] cmc_slot_t;
  typedef logic [2:0] cmc_phase_t;
endpackage

/* hdl/cmc_strobe_ff.sv */
// One strobe flip-flop with set, clear and restart.
// Assumes set and clear come from logic on aclk.
`timescale 1ns/1ns
`default_nettype none
module cmc_strobe_ff (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic restart,
  input  wire logic set_en,
  input  wire logic clr,
  output logic      q
);
  // Restart and clear win over set.
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      q <= 1'b0;
    end else if (clr) begin
      q <= 1'b0;
    end else if (set_en) begin
      q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* hdl/cmc_line_decode.sv */
// One-of-N decoder for a selection coordinate.
// Assumes the index comes from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module cmc_line_decode #(
  parameter int W = 6
) (
  input  wire logic [W-1:0]    idx,
  input  wire logic            en,
  output logic [(1<<W)-1:0]    line
);
  always_comb begin
    line = '0;
    line[idx] = en;
  end
endmodule
`default_nettype wire

/* hdl/cmc_core.sv */
// Cycle timing for the writable core store, with an AXI4-Lite slave.
// Assumes slot, phase and processor signals come from logic on aclk.
//
// Behaviour
// [R1] - All strobes fall within slots one to twelve.
// [R2] - Select when bits 11,12 zero, qualifying subinstruction.
// [R3] - Read-half strobes set only while selected.
// [R4] - Set strobe T03 to T05 phase3; clampable.
// [R5] - Sense strobe set T04 unless register addressed.
// [R6] - X read at T03 ph3, Y at ph4.
// [R7] - Both reads end at T05 phase three.
// [R8] - Restart clears set, sense, read strobes.
// [R9] - Second-half enable at select and T05.
// [R10] - Writes start T10 ph3/ph4, end T12 ph3.
// [R11] - Both reset strobes rise at T10 ph3.
// [R12] - Reset strobe clears at phase four, T02.
// [R13] - Inhibit strobe from T10 to T01.
// [R14] - Cycle complete after strobes; clears write side.
// [R15] - Inhibit drive for each zero buffer bit.
// [R16] - Read word: eight direct, eight via fixed.
// [R17] - Decode 64 X and 32 Y lines.
// [R18] - Read current needs selects, set, read.
// [R19] - Reset reverses switches before write current.
// [R20] - Location cleared before every write.
// [R21] - Timing source supplies slots and phases cyclically.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cmc_regs.svh"
module cmc_core (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire cmc_pkg::cmc_slot_t  time_slot,
  input  wire cmc_pkg::cmc_phase_t phase,
  input  wire logic [11:0]         s_addr,
  input  wire logic                bank_bit,
  input  wire logic                subinstr_transfer_control,
  input  wire logic                subinstr_inout,
  input  wire logic                subinstr_counter_increment,
  input  wire logic                subinstr_restart,
  input  wire logic                flipflop_register_addressed,
  input  wire logic                monitor_clamp,
  input  wire logic                global_restart,
  input  wire logic                stop_request,
  input  wire logic                trap_input,
  input  wire logic [15:0]         buffer_word,
  input  wire logic [7:0]          sense_direct,
  input  wire logic [7:0]          sense_fixed,
  output logic                     writable_store_select,
  output logic                     set_strobe,
  output logic                     sense_strobe,
  output logic                     read_strobe_x,
  output logic                     read_strobe_y,
  output logic                     second_half_enable,
  output logic                     write_strobe_x,
  output logic                     write_strobe_y,
  output logic                     reset_strobe_x,
  output logic                     reset_strobe_y,
  output logic                     inhibit_strobe,
  output logic                     cycle_complete,
  output logic [15:0]              inhibit_drive,
  output logic [63:0]              x_read_line,
  output logic [31:0]              y_read_line,
  output logic [63:0]              x_write_line,
  output logic [31:0]              y_write_line,
  output logic [15:0]              read_word,
  output logic                     read_word_valid
);
  logic [1:0]  ctrl_reg;
  logic [31:0] cycles_reg;
  logic        sense_d_reg;
  logic        switch_rev;
  logic [15:0] sense_word;
  logic [63:0] x_line;
  logic [31:0] y_line;
  logic        sel_next;
  logic        clamp;
  logic        s3p3, s3p4, s5p3, s10p3, s10p4, s12p3, s2p4;
  logic        cc_next;
  logic        ww_go;
  logic [10:0] loc;

  // Slot and phase coincidences that key the strobes. [R1] [R21]
  assign s3p3  = time_slot == `CMC_T03 && phase == `CMC_PH3;
  assign s3p4  = time_slot == `CMC_T03 && phase == `CMC_PH4;
  assign s5p3  = time_slot == `CMC_T05 && phase == `CMC_PH3;
  assign s10p3 = time_slot == `CMC_T10 && phase == `CMC_PH3;
  assign s10p4 = time_slot == `CMC_T10 && phase == `CMC_PH4;
  assign s12p3 = time_slot == `CMC_T12 && phase == `CMC_PH3;
  assign s2p4  = time_slot == `CMC_T02 && phase == `CMC_PH4;
  assign clamp = monitor_clamp || ctrl_reg[`CMC_CTRL_CLAMP];

  // Store select from the address and subinstruction. [R2]
  assign sel_next = ctrl_reg[`CMC_CTRL_EN]
                 && !s_addr[`CMC_SBIT11] && !s_addr[`CMC_SBIT12]
                 && (subinstr_transfer_control || subinstr_inout
                  || subinstr_counter_increment || subinstr_restart);

  always_ff @(posedge aclk) begin
    if (!aresetn || global_restart) begin
      writable_store_select <= 1'b0;
    end else begin
      writable_store_select <= sel_next;
    end
  end

  // Read half of the cycle. [R3] [R4] [R5] [R6] [R7] [R8]
  cmc_strobe_ff u_set (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (writable_store_select && time_slot == `CMC_T03),
    .clr     (s5p3 || clamp),
    .q       (set_strobe)
  );
  cmc_strobe_ff u_sense (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (writable_store_select && time_slot == `CMC_T04
              && !flipflop_register_addressed),
    .clr     (time_slot == `CMC_T05),
    .q       (sense_strobe)
  );
  cmc_strobe_ff u_rdx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (writable_store_select && s3p3),
    .clr     (s5p3),
    .q       (read_strobe_x)
  );
  cmc_strobe_ff u_rdy (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (writable_store_select && s3p4),
    .clr     (s5p3),
    .q       (read_strobe_y)
  );

  // Write half of the cycle. [R9] [R10] [R11] [R12] [R13] [R14]
  cmc_strobe_ff u_half (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (writable_store_select && time_slot == `CMC_T05),
    .clr     (cycle_complete),
    .q       (second_half_enable)
  );
  cmc_strobe_ff u_wrx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (second_half_enable && s10p3),
    .clr     (s12p3 || cycle_complete),
    .q       (write_strobe_x)
  );
  cmc_strobe_ff u_wry (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (second_half_enable && s10p4),
    .clr     (s12p3 || cycle_complete),
    .q       (write_strobe_y)
  );
  cmc_strobe_ff u_rstx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (second_half_enable && s10p3),
    .clr     (s2p4),
    .q       (reset_strobe_x)
  );
  cmc_strobe_ff u_rsty (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (second_half_enable && s10p3),
    .clr     (s2p4),
    .q       (reset_strobe_y)
  );
  cmc_strobe_ff u_inh (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (second_half_enable && time_slot == `CMC_T10),
    .clr     (time_slot == `CMC_T01 || cycle_complete),
    .q       (inhibit_strobe)
  );

  // The switches stay reversed from reset until the next set strobe. [R19] [R20]
  cmc_strobe_ff u_rev (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (global_restart),
    .set_en  (reset_strobe_x && reset_strobe_y),
    .clr     (set_strobe),
    .q       (switch_rev)
  );

  // Completion waits for both write strobes and the inhibit strobe to drop; the reset strobes stay up until T02. [R14]
  assign cc_next = second_half_enable && time_slot == `CMC_T01
                && phase == `CMC_PH5 && !stop_request && !trap_input
                && !write_strobe_x && !write_strobe_y && !inhibit_strobe;

  always_ff @(posedge aclk) begin
    if (!aresetn || global_restart) begin
      cycle_complete <= 1'b0;
    end else begin
      cycle_complete <= cc_next && !cycle_complete;
    end
  end

  // Inhibit current flows only for zero bits. [R15]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inhibit_drive <= '0;
    end else begin
      inhibit_drive <= inhibit_strobe ? ~buffer_word : '0;
    end
  end

  // Coordinate decode of the location. [R17]
  assign loc = {bank_bit, s_addr[9:0]};
  cmc_line_decode #(.W(6)) u_xdec (
    .idx  (loc[`CMC_X_MSB:`CMC_X_LSB]),
    .en   (writable_store_select),
    .line (x_line)
  );
  cmc_line_decode #(.W(5)) u_ydec (
    .idx  (loc[`CMC_Y_MSB:`CMC_Y_LSB]),
    .en   (writable_store_select),
    .line (y_line)
  );

  // Bottom and top selects both come from the decoded line. [R18] [R19]
  assign ww_go = switch_rev && !set_strobe;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_read_line  <= '0;
      y_read_line  <= '0;
      x_write_line <= '0;
      y_write_line <= '0;
    end else begin
      x_read_line  <= x_line & {64{set_strobe && read_strobe_x}};
      y_read_line  <= y_line & {32{set_strobe && read_strobe_y}};
      x_write_line <= x_line & {64{ww_go && write_strobe_x}};
      y_write_line <= y_line & {32{ww_go && write_strobe_y}};
    end
  end

  // Even planes pass through the fixed amplifiers, odd ones go direct. [R16]
  for (genvar i = 0; i < 8; i++) begin : g_sense
    assign sense_word[2*i]   = sense_fixed[i];
    assign sense_word[2*i+1] = sense_direct[i];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_word       <= '0;
      sense_d_reg     <= 1'b0;
      read_word_valid <= 1'b0;
    end else begin
      sense_d_reg     <= sense_strobe;
      read_word_valid <= sense_d_reg && !sense_strobe;
      if (sense_strobe) begin
        read_word <= sense_word;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycles_reg <= '0;
    end else if (cycle_complete) begin
      cycles_reg <= cycles_reg + 32'h1;
    end
  end

  // AXI4-Lite slave: address and data are taken in either order.
  logic        aw_held, w_held;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [7:0]  waddr, raddr;
  logic [31:0] status_word;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign waddr = aw_addr_reg & `CMC_WORD_MASK;
  assign raddr = s_axi_araddr & `CMC_WORD_MASK;
  assign status_word = {21'h0, writable_store_select, set_strobe,
                        sense_strobe, read_strobe_x, read_strobe_y,
                        second_half_enable, write_strobe_x,
                        write_strobe_y, reset_strobe_x, inhibit_strobe,
                        switch_rev};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cmc_pkg::CMC_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waddr == `CMC_OFF_CTRL || waddr == `CMC_OFF_STATUS
                      || waddr == `CMC_OFF_CYCLES || waddr == `CMC_OFF_WORD)
                      ? cmc_pkg::CMC_OKAY : cmc_pkg::CMC_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `CMC_CTRL_RST;
    end else if (aw_held && w_held && !s_axi_bvalid
                 && waddr == `CMC_OFF_CTRL && w_strb_reg[0]) begin
      ctrl_reg <= w_data_reg[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= cmc_pkg::CMC_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= cmc_pkg::CMC_OKAY;
      unique case (raddr)
        `CMC_OFF_CTRL:   s_axi_rdata <= {30'h0, ctrl_reg};
        `CMC_OFF_STATUS: s_axi_rdata <= status_word;
        `CMC_OFF_CYCLES: s_axi_rdata <= cycles_reg;
        `CMC_OFF_WORD:   s_axi_rdata <= {16'h0, read_word};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= cmc_pkg::CMC_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SEL_GATE: assert property ( // [R3]
    $rose(set_strobe) || $rose(read_strobe_x) |-> $past(writable_store_select))
    else $error("read-half strobe rose without select");
  AST_SET_START: assert property ( // [R4]
    $rose(set_strobe) |-> $past(time_slot) == `CMC_T03 && !$past(clamp))
    else $error("set strobe rose outside slot three");
  AST_SET_END: assert property ( // [R4]
    set_strobe && s5p3 |=> !set_strobe)
    else $error("set strobe outlived slot five phase three");
  AST_SENSE: assert property ( // [R5]
    $rose(sense_strobe) |-> $past(time_slot == `CMC_T04
                                   && !flipflop_register_addressed))
    else $error("sense strobe rose wrongly");
  AST_RD_Y: assert property ( // [R6]
    $rose(read_strobe_y) |-> $past(s3p4))
    else $error("Y read strobe rose off slot three phase four");
  AST_RD_END: assert property ( // [R7]
    (read_strobe_x || read_strobe_y) && s5p3 |=> !read_strobe_x && !read_strobe_y)
    else $error("read strobes not ended together");
  AST_RESTART: assert property ( // [R8]
    global_restart |=> !(set_strobe || sense_strobe || read_strobe_x || read_strobe_y))
    else $error("restart left a strobe set");
  AST_HALF: assert property ( // [R9]
    $rose(write_strobe_x) || $rose(inhibit_strobe) |-> $past(second_half_enable))
    else $error("write-side strobe without second-half enable");
  AST_WR_END: assert property ( // [R10]
    (write_strobe_x || write_strobe_y) && s12p3 |=> !write_strobe_x && !write_strobe_y)
    else $error("write strobes outlived slot twelve phase three");
  AST_RST_PAIR: assert property ( // [R11]
    $rose(reset_strobe_x) |-> $rose(reset_strobe_y) && $past(s10p3))
    else $error("reset strobes not raised together at slot ten");
  AST_RST_END: assert property ( // [R12]
    reset_strobe_x && s2p4 |=> !reset_strobe_x)
    else $error("reset strobe outlived phase four slot two");
  AST_CC: assert property ( // [R14]
    cycle_complete |-> !write_strobe_x && !inhibit_strobe ##1 !second_half_enable)
    else $error("cycle complete before strobes ended");
  AST_INH_DRV: assert property ( // [R15]
    inhibit_strobe |=> inhibit_drive == ~$past(buffer_word))
    else $error("inhibit drive does not follow zero bits");
  AST_RD_LINE: assert property ( // [R18]
    |x_read_line |-> $past(set_strobe && read_strobe_x && writable_store_select))
    else $error("read current without set and read strobes");
  AST_WR_REV: assert property ( // [R19] [R20]
    |x_write_line || |y_write_line |-> $past(switch_rev))
    else $error("write current before switches were reset");

  COV_READ: cover property ($rose(sense_strobe) ##[1:200] read_word_valid);
  COV_WRITE: cover property ($rose(reset_strobe_x) ##[1:200] |x_write_line);
  COV_DONE: cover property ($rose(second_half_enable) ##[1:500] cycle_complete);
endmodule
`default_nettype wire

/* tb/cmc_cpu_model.sv */
// Processor-side model: cyclic slot and phase source plus address and buffer registers.
// Assumes loads come from the bench on aclk.
`timescale 1ns/1ns
`default_nettype none
`include "cmc_regs.svh"
module cmc_cpu_model (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           ld,
  input  wire logic [11:0]    addr_in,
  input  wire logic           bank_in,
  input  wire logic [15:0]    buf_in,
  output cmc_pkg::cmc_slot_t  time_slot,
  output cmc_pkg::cmc_phase_t phase,
  output logic [11:0]         s_addr,
  output logic                bank_bit,
  output logic [15:0]         buffer_word
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_slot <= `CMC_T12;
      phase     <= `CMC_PH5;
    end else if (phase == `CMC_PH5) begin
      phase     <= 3'h1;
      time_slot <= (time_slot == `CMC_T12) ? `CMC_T01 : time_slot + 4'h1;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  // Out of reset the address points outside the writable store.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_addr      <= 12'hc00;
      bank_bit    <= 1'b0;
      buffer_word <= 16'h0;
    end else if (ld) begin
      s_addr      <= addr_in;
      bank_bit    <= bank_in;
      buffer_word <= buf_in;
    end
  end
endmodule
`default_nettype wire

/* tb/cmc_core_tb_top.sv */
// Self-checking bench for the core memory cycle timing block.
// Assumes the processor model supplies slots, phases, address and buffer word.
`timescale 1ns/1ns
`default_nettype none
`include "cmc_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module cmc_core_tb_top;
  localparam logic [1:0] rsp_ok = cmc_pkg::CMC_OKAY;
  localparam logic [1:0] rsp_err = cmc_pkg::CMC_SLVERR;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, sdir = 8'h0, sfix = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, ywl;
  logic        awready, wready, bvalid, arready, rvalid, sel, rw_v, bank_bit;
  logic [1:0]  bresp, rresp, eb;
  logic [3:0]  subi = 4'h0;
  logic        ffa = 1'b0, clamp = 1'b0, rst_g = 1'b0, ld = 1'b0, bank_in = 1'b0, inh_d = 1'b0;
  logic [11:0] addr_in = 12'hc00, s_addr;
  logic [15:0] buf_in = 16'h0, buffer_word, inh_drv, rword, ew, lastw;
  logic [63:0] xrl, xwl;
  logic [31:0] yrl;
  logic [33:0] er;
  wire  [11:0] sv;
  cmc_pkg::cmc_slot_t  slot;
  cmc_pkg::cmc_phase_t ph;
  int          err_count = 0, n_compared = 0, cyc = 0, seed = 19706;
  int          cnt[12] = '{default: 0};
  int          base[12];
  int          nrm[12] = '{9, 10, 1, 15, 21, 21, 9, 10, 9, 10, 5, 12};
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [15:0] wq[$];

  always #5 aclk = ~aclk;
  assign sv[1] = |xrl;
  assign sv[0] = |ywl;

  cmc_cpu_model u_cpu (.aclk(aclk), .aresetn(aresetn), .ld(ld), .addr_in(addr_in),
    .bank_in(bank_in), .buf_in(buf_in), .time_slot(slot), .phase(ph), .s_addr(s_addr),
    .bank_bit(bank_bit), .buffer_word(buffer_word));

  cmc_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .time_slot(slot), .phase(ph), .s_addr(s_addr), .bank_bit(bank_bit),
    .subinstr_transfer_control(subi[0]), .subinstr_inout(subi[1]),
    .subinstr_counter_increment(subi[2]), .subinstr_restart(subi[3]),
    .flipflop_register_addressed(ffa), .monitor_clamp(clamp), .global_restart(rst_g),
    .stop_request(1'b0), .trap_input(1'b0), .buffer_word(buffer_word), .sense_direct(sdir),
    .sense_fixed(sfix), .writable_store_select(sel), .set_strobe(sv[11]),
    .sense_strobe(sv[10]), .read_strobe_x(sv[9]), .read_strobe_y(sv[8]),
    .second_half_enable(), .write_strobe_x(sv[7]), .write_strobe_y(sv[6]),
    .reset_strobe_x(sv[5]), .reset_strobe_y(sv[4]), .inhibit_strobe(sv[3]),
    .cycle_complete(sv[2]), .inhibit_drive(inh_drv), .x_read_line(xrl), .y_read_line(yrl),
    .x_write_line(xwl), .y_write_line(ywl), .read_word(rword), .read_word_valid(rw_v));

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Strobe widths are counted at the falling edge, clear of the launch edge.
  always @(negedge aclk) begin
    foreach (cnt[i]) cnt[i] += sv[i];
    if (aresetn) begin
      `CHK("inhibit", inh_d ? ~buffer_word : 16'h0, inh_drv)
      if (|xrl) `CHK("xline", 64'h1 << s_addr[5:0], xrl)
      if (|ywl) `CHK("yline", 32'h1 << {bank_bit, s_addr[9:6]}, ywl)
      if (|yrl) `CHK("yrline", 32'h1 << {bank_bit, s_addr[9:6]}, yrl)
      if (|xwl) `CHK("xwline", 64'h1 << s_addr[5:0], xwl)
    end
    inh_d = sv[3];
  end

  always @(posedge aclk) begin
    if (rvalid && rready) begin
      er = rq.size() ? rq.pop_front() : 34'bx;
      `CHK("axi read", er, {rresp, rdata})
    end
    if (bvalid && bready) begin
      eb = bq.size() ? bq.pop_front() : 2'bx;
      `CHK("axi resp", eb, bresp)
    end
    if (rw_v) begin
      ew = wq.size() ? wq.pop_front() : 16'bx;
      `CHK("read word", ew, rword)
    end
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic wait_at(input cmc_pkg::cmc_slot_t s, input cmc_pkg::cmc_phase_t p);
    do @(posedge aclk); while (!(slot == s && ph == p));
  endtask

  // One memory cycle with the case's inputs, then one idle cycle, then width checks.
  task automatic run_case(input int k);
    logic [7:0]  d, f;
    logic [15:0] w;
    int          e[12];
    e = nrm;
    d = 8'($random(seed));
    f = 8'($random(seed));
    for (int i = 0; i < 8; i++) begin
      w[2 * i] = f[i];
      w[2 * i + 1] = d[i];
    end
    if (k == 4) begin
      e[11] = 0;
      e[1] = 0;
    end
    if (k == 5) e[10] = 0;
    if (k > 5) e = '{default: 0};
    wait_at(`CMC_T12, 3'h4);
    addr_in <= {k == 7, k == 6, 10'($random(seed))};
    bank_in <= 1'($random(seed));
    buf_in <= 16'($random(seed));
    sdir <= d;
    sfix <= f;
    subi <= (k == 8) ? 4'h0 : 4'h1 << (k % 4);
    clamp <= (k == 4);
    ffa <= (k == 5 || k == 9);
    ld <= 1'b1;
    base = cnt;
    if (k < 5) begin
      wq.push_back(w);
      lastw = w;
    end
    @(posedge aclk);
    ld <= 1'b0;
    if (k == 9) begin
      wait_at(`CMC_T04, 3'h1);
      rst_g <= 1'b1;
      @(posedge aclk);
      rst_g <= 1'b0;
      @(negedge aclk);
      `CHK("restart", 5'h0, {sel, sv[11:8]})
    end
    wait_at(`CMC_T12, 3'h4);
    addr_in <= 12'hc00;
    ld <= 1'b1;
    @(posedge aclk);
    ld <= 1'b0;
    repeat (60) @(posedge aclk);
    if (k != 9) foreach (e[i]) `CHK("strobe cycles", e[i], cnt[i] - base[i])
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CMC_OFF_CTRL, {rsp_ok, 32'h1});
    rd(`CMC_OFF_STATUS, {rsp_ok, 32'h0});
    wr(`CMC_OFF_CTRL, 32'h3, rsp_ok);
    rd(`CMC_OFF_CTRL, {rsp_ok, 32'h3});
    wr(`CMC_OFF_CTRL, 32'h1, rsp_ok);
    wr(`CMC_OFF_STATUS, 32'h7ff, rsp_ok);
    wr(8'h10, 32'h0, rsp_err);
    rd(8'h10, {rsp_err, 32'h0});
    for (int k = 0; k < 9; k++) run_case(k);
    rd(`CMC_OFF_CYCLES, {rsp_ok, 32'h6});
    rd(`CMC_OFF_STATUS, {rsp_ok, 32'h1});
    rd(`CMC_OFF_WORD, {rsp_ok, 16'h0, lastw});
    run_case(9);
    end_sim();
  end
endmodule
`default_nettype wire
